// >>> card_detect_compare.sv
/*
 border comparison for one detection result.
 assumes the borders and values are stable while the strobe is high.
*/
`timescale 1ns/1ns
`default_nettype none
module card_detect_compare
(
    // measured values
    input  wire card_detect_pkg::meas_t i_value,
    input  wire card_detect_pkg::meas_t q_value,
    // borders
    input  wire card_detect_pkg::meas_t i_lower_border,
    input  wire card_detect_pkg::meas_t i_upper_border,
    input  wire card_detect_pkg::meas_t q_lower_border,
    input  wire card_detect_pkg::meas_t q_upper_border,
    // verdict
    output logic                        out_of_band
);
    // unsigned compare, shared by every border check
    function automatic logic above(input card_detect_pkg::meas_t v, input card_detect_pkg::meas_t b);
        above = (v > b);
    endfunction : above

    always_comb
    begin
        out_of_band = above(i_value, i_upper_border)
                    | above(q_value, q_lower_border)
                    | above(q_value, q_upper_border)
                    | above(i_lower_border, i_value);
    end
endmodule : card_detect_compare
`default_nettype wire

// >>> card_detect_map.svh
/*
 register offsets, field positions and reset values of the low-power card detect window.
 assumes byte offsets derived as four times the printed register index on a 32-bit avalon bus.
*/
`ifndef CARD_DETECT_MAP_SVH
`define CARD_DETECT_MAP_SVH

// printed register indices
`define IDX_Q_LOWER_BORDER   8'h3f
`define IDX_Q_UPPER_BORDER   8'h40
`define IDX_I_LOWER_BORDER   8'h41
`define IDX_I_RESULT         8'h42
`define IDX_Q_RESULT         8'h43
`define IDX_IRQ_STATUS       8'h50
`define IDX_IRQ_ENABLE       8'h51
`define IDX_IRQ_CLEAR        8'h52

// byte addresses
`define ADDR_Q_LOWER_BORDER  10'h0fc
`define ADDR_Q_UPPER_BORDER  10'h100
`define ADDR_I_LOWER_BORDER  10'h104
`define ADDR_I_RESULT        10'h108
`define ADDR_Q_RESULT        10'h10c
`define ADDR_IRQ_STATUS      10'h140
`define ADDR_IRQ_ENABLE      10'h144
`define ADDR_IRQ_CLEAR       10'h148

// fields
`define BORDER_LSB           0
`define BORDER_MSB           5
`define IUB_HI_LSB           6
`define SUPPRESS_BIT         6
`define CARD_DETECT_BIT      0
`define IRQ_BITS             1

// reset values
`define BORDER_REG_RESET     8'h00
`define RESULT_RESET         6'h00
`define IRQ_ENABLE_RESET     1'h0
`define UNMAPPED_READ        32'h00000000

`endif

// >>> card_detect_pkg.sv
/*
 types shared by the card detect window.
 assumes nothing of its surroundings.
*/
package card_detect_pkg;
    typedef logic [5:0] meas_t;
    typedef enum logic [1:0]
    {
        bus_idle  = 2'b00,
        bus_reply = 2'b01
    } bus_state_t;
endpackage : card_detect_pkg

// >>> card_detect_window.sv
/*
 low-power card detect threshold and result block with avalon-mm register slave and interrupt.
 assumes the measurement front end pulses meas_done for one clock with the values valid,
 and pulses run_start when a new detection run begins.
*/
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "card_detect_map.svh"

// Notes on behaviour
// - i upper border assembled from top two bits of three border registers
// - i value above i upper border raises the card detect flag
// - q value above q lower border raises the flag, polarity as printed
// - q value above q upper border raises the flag
// - i value below i lower border raises the flag
// - i result readable in bits 5:0, bits 7:6 read zero
// - q result readable in bits 5:0, bit 7 reads zero
// - suppress bit blocks further detect interrupts until next run starts
module card_detect_window
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // measurement front end
    input  wire logic        run_start,
    input  wire logic        meas_done,
    input  wire logic [5:0]  meas_i,
    input  wire logic [5:0]  meas_q,
    // interrupt
    output logic             irq
);
    logic                        rst_sync1;
    logic                        rst_sync_n;
    logic [7:0]                  q_lower_border_reg;
    logic [7:0]                  q_upper_border_reg;
    logic [7:0]                  i_lower_border_reg;
    card_detect_pkg::meas_t      i_last_result;
    card_detect_pkg::meas_t      q_last_result;
    logic                        detect_irq_suppress;
    logic [`IRQ_BITS-1:0]        irq_status_first;
    logic [`IRQ_BITS-1:0]        irq_enable;
    card_detect_pkg::meas_t      i_upper_border;
    logic                        out_of_band;
    logic                        detect_event;
    card_detect_pkg::bus_state_t bus_state;
    card_detect_pkg::bus_state_t next_bus_state;
    logic                        wr_take;
    logic                        rd_take;
    logic                        lane0;
    logic [31:0]                 next_readdata;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync1  <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_sync1  <= 1'b1;
            rst_sync_n <= rst_sync1;
        end
    end

    // one wait cycle per access: request is seen, then answered
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            bus_state <= card_detect_pkg::bus_idle;
        else
            bus_state <= next_bus_state;
    end

    always_comb
    begin
        case (bus_state)
            card_detect_pkg::bus_idle:
                next_bus_state = (read | write) ? card_detect_pkg::bus_reply : card_detect_pkg::bus_idle;
            card_detect_pkg::bus_reply:
                next_bus_state = card_detect_pkg::bus_idle;
            default:
                next_bus_state = card_detect_pkg::bus_idle;
        endcase
    end

    assign waitrequest = (read | write) & (bus_state != card_detect_pkg::bus_reply);
    assign wr_take     = write & (bus_state == card_detect_pkg::bus_reply);
    assign rd_take     = read & (bus_state == card_detect_pkg::bus_reply);
    assign lane0       = byteenable[0];

    // border registers
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            q_lower_border_reg <= `BORDER_REG_RESET;
            q_upper_border_reg <= `BORDER_REG_RESET;
            i_lower_border_reg <= `BORDER_REG_RESET;
        end
        else if (wr_take && lane0)
        begin
            if (address == `ADDR_Q_LOWER_BORDER)
                q_lower_border_reg <= writedata[7:0];
            if (address == `ADDR_Q_UPPER_BORDER)
                q_upper_border_reg <= writedata[7:0];
            if (address == `ADDR_I_LOWER_BORDER)
                i_lower_border_reg <= writedata[7:0];
        end
    end

    assign i_upper_border = {q_lower_border_reg[7:6], q_upper_border_reg[7:6], i_lower_border_reg[7:6]};

    card_detect_compare u_compare
    (
        .i_value        (meas_i),
        .q_value        (meas_q),
        .i_lower_border (i_lower_border_reg[`BORDER_MSB:`BORDER_LSB]),
        .i_upper_border (i_upper_border),
        .q_lower_border (q_lower_border_reg[`BORDER_MSB:`BORDER_LSB]),
        .q_upper_border (q_upper_border_reg[`BORDER_MSB:`BORDER_LSB]),
        .out_of_band    (out_of_band)
    );

    // results captured only at measurement completion
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            i_last_result <= `RESULT_RESET;
            q_last_result <= `RESULT_RESET;
        end
        else if (meas_done)
        begin
            i_last_result <= meas_i;
            q_last_result <= meas_q;
        end
    end

    // suppress: software sets, a new run clears; a write in the run_start cycle wins
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            detect_irq_suppress <= 1'b0;
        else if (wr_take && lane0 && address == `ADDR_Q_RESULT)
            detect_irq_suppress <= writedata[`SUPPRESS_BIT];
        else if (run_start)
            detect_irq_suppress <= 1'b0;
    end

    assign detect_event = meas_done & out_of_band & ~detect_irq_suppress;

    // sticky status: set wins over clear
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            irq_status_first <= '0;
        else
        begin
            if (wr_take && lane0 && address == `ADDR_IRQ_CLEAR)
                irq_status_first[`CARD_DETECT_BIT] <= 1'b0;
            if (detect_event)
                irq_status_first[`CARD_DETECT_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            irq_enable <= `IRQ_ENABLE_RESET;
        else if (wr_take && lane0 && address == `ADDR_IRQ_ENABLE)
            irq_enable <= writedata[`IRQ_BITS-1:0];
    end

    assign irq = |(irq_status_first & irq_enable);

    // read mux; reserved bits and unmapped addresses read zero
    always_comb
    begin
        next_readdata = `UNMAPPED_READ;
        case (address)
            `ADDR_Q_LOWER_BORDER: next_readdata = {24'h000000, q_lower_border_reg};
            `ADDR_Q_UPPER_BORDER: next_readdata = {24'h000000, q_upper_border_reg};
            `ADDR_I_LOWER_BORDER: next_readdata = {24'h000000, i_lower_border_reg};
            `ADDR_I_RESULT:       next_readdata = {26'h0000000, i_last_result};
            `ADDR_Q_RESULT:       next_readdata = {25'h0000000, detect_irq_suppress, q_last_result};
            `ADDR_IRQ_STATUS:     next_readdata = {31'h00000000, irq_status_first};
            `ADDR_IRQ_ENABLE:     next_readdata = {31'h00000000, irq_enable};
            default:              next_readdata = `UNMAPPED_READ;
        endcase
    end

    // readdata registered in the wait cycle so it stands at the accepting edge
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            readdata <= '0;
        else if (read && bus_state == card_detect_pkg::bus_idle)
            readdata <= next_readdata;
        else if (rd_take)
            readdata <= readdata;
    end
endmodule : card_detect_window
`default_nettype wire

// >>> card_detect_window_props.sv
/*
 concurrent checks of the card detect window.
 assumes only the top ports are seen; borders are shadowed from accepted writes.
*/
`timescale 1ns/1ns
`default_nettype none
`include "card_detect_map.svh"
module card_detect_window_props
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // avalon-mm slave
    input wire logic [9:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // front end and interrupt
    input wire logic        run_start,
    input wire logic        meas_done,
    input wire logic [5:0]  meas_i,
    input wire logic [5:0]  meas_q,
    input wire logic        irq
);
    logic [7:0] qlo, qhi, ilo;
    logic [5:0] last_i, last_q, iub;
    logic       en, sup, oob, acc;
    assign acc = write && !waitrequest && byteenable[0];
    assign iub = {qlo[7:6], qhi[7:6], ilo[7:6]};
    assign oob = meas_i > iub || meas_i < ilo[5:0] || meas_q > qlo[5:0] || meas_q > qhi[5:0];
    // shadow copy moves on accepted writes, run_start and meas_done only, so a refused cycle cannot move it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {qlo, qhi, ilo, last_i, last_q, en, sup} <= '0;
        end
        else
        begin
            if (acc && address == `ADDR_Q_LOWER_BORDER) qlo <= writedata[7:0];
            if (acc && address == `ADDR_Q_UPPER_BORDER) qhi <= writedata[7:0];
            if (acc && address == `ADDR_I_LOWER_BORDER) ilo <= writedata[7:0];
            if (acc && address == `ADDR_IRQ_ENABLE) en <= writedata[0];
            if (acc && address == `ADDR_Q_RESULT) sup <= writedata[6];
            else if (run_start) sup <= 1'b0;
            if (meas_done) last_i <= meas_i;
            if (meas_done) last_q <= meas_q;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wait_first_a: assert property ($rose(read || write) |-> waitrequest) else $error("no wait state");
    wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("wait too long");
    detect_raise_a: assert property (meas_done && oob && !sup && en |=> irq) else $error("no irq");
    band_quiet_a: assert property (meas_done && !oob && !irq && !acc |=> !irq) else $error("false irq");
    suppress_hold_a: assert property (sup && !irq && !acc |=> !irq) else $error("irq while suppressed");
    irq_clear_a: assert property (acc && address == `ADDR_IRQ_CLEAR && !meas_done |=> !irq) else $error("irq kept");
    irq_mask_a: assert property (!en |-> !irq) else $error("masked irq");
    i_result_a: assert property (read && !waitrequest && address == `ADDR_I_RESULT
        |-> readdata[7:0] == {2'b00, last_i}) else $error("i result");
    q_result_a: assert property (read && !waitrequest && address == `ADDR_Q_RESULT
        |-> readdata[7:0] == {1'b0, sup, last_q}) else $error("q result");
    read_hold_a: assert property (!read |=> $stable(readdata)) else $error("readdata moved");
endmodule : card_detect_window_props
`default_nettype wire

// >>> card_detect_window_tb.sv
/*
 self-checking bench of the card detect window.
 assumes the design, map header and checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "card_detect_map.svh"
module card_detect_window_tb;
    logic        clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, run_start = 1'b0, meas_done = 1'b0;
    logic        waitrequest, irq;
    logic [9:0]  address = 10'h000;
    logic [31:0] writedata = 32'h0, readdata;
    logic [5:0]  meas_i = 6'h00, meas_q = 6'h00;
    logic [7:0]  rd;
    int          n_fail = 0, n_checks = 0;
    // qlo, i, q, irq expected; i upper border is 6'h27, i lower 6'h04, q upper 6'h30
    logic [20:0] tc [7] = '{{8'h8a, 6'd39, 6'd10, 1'b0}, {8'h8a, 6'd40, 6'd10, 1'b1}, {8'h8a, 6'd3, 6'd10, 1'b1},
        {8'h8a, 6'd4, 6'd11, 1'b1}, {8'h8a, 6'd63, 6'd0, 1'b1}, {8'hbf, 6'd39, 6'd48, 1'b0}, {8'hbf, 6'd39, 6'd49, 1'b1}};
    card_detect_window i_card_detect_window
    (
        .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest), .run_start(run_start),
        .meas_done(meas_done), .meas_i(meas_i), .meas_q(meas_q), .irq(irq)
    );
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one request held until waitrequest is sampled low at a rising edge; data taken at that edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        logic ok;
        ok = 1'b0;
        address   <= a;
        writedata <= {24'h0, d};
        write     <= wr;
        read      <= !wr;
        for (int k = 0; k < 20 && !ok; k++)
        begin
            @(posedge clk);
            ok = (waitrequest === 1'b0);
        end
        rd = readdata[7:0];
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge clk);
        if (!ok)
        begin
            n_fail++;
            $display("BAD %0t bus hang", $time);
            complete_run();
        end
    endtask : bus
    task automatic pulse(input logic [5:0] i, input logic [5:0] q);
        meas_i    <= i;
        meas_q    <= q;
        meas_done <= 1'b1;
        @(posedge clk);
        meas_done <= 1'b0;
        @(posedge clk);
    endtask : pulse
    task automatic measure(input logic [5:0] i, input logic [5:0] q, input logic sup, input logic exp);
        pulse(i, q);
        chk({7'h0, irq}, {7'h0, exp});
        bus(1'b0, `ADDR_IRQ_STATUS, 8'h00);
        chk(rd, {7'h0, exp});
        bus(1'b0, `ADDR_I_RESULT, 8'h00);
        chk(rd, {2'b00, i});
        bus(1'b0, `ADDR_Q_RESULT, 8'h00);
        chk(rd, {1'b0, sup, q});
        bus(1'b1, `ADDR_IRQ_CLEAR, 8'h01);
        chk({7'h0, irq}, 8'h00);
    endtask : measure
    task automatic regs_and_reset();
        logic [9:0] a [6] = '{`ADDR_Q_LOWER_BORDER, `ADDR_Q_UPPER_BORDER, `ADDR_I_LOWER_BORDER,
            `ADDR_I_RESULT, `ADDR_Q_RESULT, 10'h3fc};
        logic [7:0] w [6] = '{8'h8a, 8'h70, 8'hc4, 8'hff, 8'h00, 8'h5a};
        logic [7:0] e [6] = '{8'h8a, 8'h70, 8'hc4, 8'h00, 8'h00, 8'h00};
        for (int k = 0; k < 6; k++)
        begin
            bus(1'b0, a[k], 8'h00);
            chk(rd, 8'h00);
            bus(1'b1, a[k], w[k]);
            bus(1'b0, a[k], 8'h00);
            chk(rd, e[k]);
        end
    endtask : regs_and_reset
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        regs_and_reset();
        bus(1'b1, `ADDR_IRQ_ENABLE, 8'h01);
        for (int k = 0; k < 7; k++)
        begin
            bus(1'b1, `ADDR_Q_LOWER_BORDER, tc[k][20:13]);
            measure(tc[k][12:7], tc[k][6:1], 1'b0, tc[k][0]);
        end
        bus(1'b1, `ADDR_Q_RESULT, 8'h40);
        measure(6'd63, 6'd0, 1'b1, 1'b0);
        run_start <= 1'b1;
        @(posedge clk);
        run_start <= 1'b0;
        measure(6'd62, 6'd1, 1'b0, 1'b1);
        bus(1'b1, `ADDR_IRQ_ENABLE, 8'h00);
        pulse(6'd63, 6'd0);
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, `ADDR_IRQ_ENABLE, 8'h01);
        chk({7'h0, irq}, 8'h01);
        complete_run();
    end
endmodule : card_detect_window_tb
bind card_detect_window card_detect_window_props i_card_detect_window_props
(
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .run_start(run_start),
    .meas_done(meas_done), .meas_i(meas_i), .meas_q(meas_q), .irq(irq)
);
`default_nettype wire
